// *** hdl/slow_rate_gen.sv ***
module slow_rate_gen
	import wakeup_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic enable,
	output logic      tick
);
	typedef struct packed {
		logic [PHASE_W-1:0] phase;
		logic               tick;
	} rate_state_t;

	localparam logic [PHASE_W-1:0] STEP = PHASE_W'(SLOW_HZ);
	localparam logic [PHASE_W-1:0] WRAP = PHASE_W'(CLK_HZ);

	rate_state_t st;
	rate_state_t next_st;

	// fractional accumulator: average rate is exact, jitter is one aclk period
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (enable) begin
			if (st.phase + STEP >= WRAP) begin
				next_st.phase = st.phase + STEP - WRAP;
				next_st.tick = 1'b1;
			end else begin
				next_st.phase = st.phase + STEP;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign tick = st.tick;

	a_rate_gated: assert property (@(posedge aclk) disable iff (!aresetn)
		!$past(enable) |-> !tick) else $error("slow tick while source disabled");
endmodule

// *** hdl/tick_prescaler.sv ***
module tick_prescaler
	import wakeup_pkg::*;
(
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic               tick_in,
	input  wire logic [PRESC_W-1:0] sel,
	output logic                    tick_out
);
	typedef struct packed {
		logic [COUNT_W-1:0] count;
		logic               tick;
	} presc_state_t;

	presc_state_t st;
	presc_state_t next_st;

	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (tick_in) begin
			if (st.count >= div_last(sel)) begin
				next_st.count = '0;
				next_st.tick = 1'b1;
			end else begin
				next_st.count = st.count + 16'h0001;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign tick_out = st.tick;

	a_presc_cause: assert property (@(posedge aclk) disable iff (!aresetn)
		tick_out |-> $past(tick_in)) else $error("prescaler tick without input tick");
endmodule

// *** hdl/wakeup_controller.sv ***
module wakeup_controller
	import wakeup_pkg::*;
#(
	parameter logic [COUNT_W-1:0] SETTLE_EDGES = SETTLE_EDGES_DEF,
	parameter logic [COUNT_W-1:0] TRIM_TICKS   = TRIM_TICKS_DEF
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axil_awaddr,
	input  wire logic [2:0]        s_axil_awprot,
	input  wire logic              s_axil_awvalid,
	output logic                   s_axil_awready,
	input  wire logic [31:0]       s_axil_wdata,
	input  wire logic [3:0]        s_axil_wstrb,
	input  wire logic              s_axil_wvalid,
	output logic                   s_axil_wready,
	output logic [1:0]             s_axil_bresp,
	output logic                   s_axil_bvalid,
	input  wire logic              s_axil_bready,
	input  wire logic [ADDR_W-1:0] s_axil_araddr,
	input  wire logic [2:0]        s_axil_arprot,
	input  wire logic              s_axil_arvalid,
	output logic                   s_axil_arready,
	output logic [31:0]            s_axil_rdata,
	output logic [1:0]             s_axil_rresp,
	output logic                   s_axil_rvalid,
	input  wire logic              s_axil_rready,
	input  wire logic              crystal_raw_level,
	input  wire logic              sleep_state,
	output logic                   rc_osc_enable,
	output logic                   crystal_osc_enable,
	output logic                   backup_ram_sleep_power,
	output logic                   wake_request
);
	if (SETTLE_EDGES == '0 || TRIM_TICKS == '0) begin : g_bad_param
		$error("settle and trim counts must be nonzero");
	end

	localparam logic [ADDR_W-1:0] A_CFG_UPPER    = {IDX_CFG_UPPER, 2'b00};
	localparam logic [ADDR_W-1:0] A_CFG_LOWER    = {IDX_CFG_LOWER, 2'b00};
	localparam logic [ADDR_W-1:0] A_RELOAD_UPPER = {IDX_RELOAD_UPPER, 2'b00};
	localparam logic [ADDR_W-1:0] A_RELOAD_LOWER = {IDX_RELOAD_LOWER, 2'b00};
	localparam logic [ADDR_W-1:0] A_FLAG_CLEAR   = {IDX_FLAG_CLEAR, 2'b00};
	localparam logic [ADDR_W-1:0] A_STATUS       = {IDX_STATUS, 2'b00};

	wake_state_t  st;
	wake_state_t  next_st;
	wake_status_t stat;

	logic               rc_tick;
	logic               xo_tick;
	logic               src_tick;
	logic               timer_tick;
	logic               timeout_event;
	logic               wr_fire;
	logic               rd_fire;
	logic               wr_mapped;
	logic               wr_cfg_lower;
	logic               wr_rel_upper;
	logic               wr_rel_lower;
	logic               wr_clear;
	logic [7:0]         status_byte;
	logic [7:0]         rd_byte;
	logic               rd_mapped;

	assign rc_osc_enable      = st.cfg_lower[CFG_RC_EN];
	assign crystal_osc_enable = st.cfg_lower[CFG_XO_EN];

	slow_rate_gen u_rc_rate (
		.aclk    (aclk),
		.aresetn (aresetn),
		.enable  (st.cfg_lower[CFG_RC_EN]),
		.tick    (rc_tick)
	);

	// crystal input is synchronous to aclk, so a plain edge detect is safe
	assign xo_tick  = st.cfg_lower[CFG_XO_EN] && crystal_raw_level && !st.xo_prev;
	assign src_tick = st.cfg_lower[CFG_SRC_SEL] ? rc_tick : xo_tick;

	tick_prescaler u_presc (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.tick_in  (src_tick),
		.sel      (st.cfg_upper[PRESC_W-1:0]),
		.tick_out (timer_tick)
	);

	// event is the step onto zero, so a held zero count does not retrigger
	assign timeout_event = timer_tick && (st.count == 16'h0001);

	assign stat.live       = (st.count == '0);
	assign stat.latched    = st.latched;
	assign stat.cold_start = st.cold_start;
	assign stat.xo_level   = crystal_raw_level;
	assign stat.xo_settled = st.xo_settled && st.cfg_lower[CFG_XO_EN];
	assign stat.trim_done  = st.trim_done && st.trim_en;
	assign stat.trim_error = st.trim_error && st.trim_en;

	assign status_byte = {1'b0, stat.trim_error, stat.trim_done, stat.xo_settled,
		stat.xo_level, stat.cold_start, stat.latched, stat.live};

	assign wr_fire      = st.aw_held && st.w_held && !st.bvalid;
	assign rd_fire      = s_axil_arvalid && !st.rvalid;
	assign wr_mapped    = st.aw_addr == A_CFG_UPPER || st.aw_addr == A_CFG_LOWER
		|| st.aw_addr == A_RELOAD_UPPER || st.aw_addr == A_RELOAD_LOWER
		|| st.aw_addr == A_FLAG_CLEAR;
	assign wr_cfg_lower = wr_fire && st.w_lane && st.aw_addr == A_CFG_LOWER;
	assign wr_rel_upper = wr_fire && st.w_lane && st.aw_addr == A_RELOAD_UPPER;
	assign wr_rel_lower = wr_fire && st.w_lane && st.aw_addr == A_RELOAD_LOWER;
	assign wr_clear     = wr_fire && st.w_lane && st.aw_addr == A_FLAG_CLEAR
		&& st.w_data[CLR_FLAGS];

	// write-only registers read as zero; flag-clear reads back the trim enable only
	always_comb begin
		rd_byte = 8'h00;
		rd_mapped = 1'b1;
		case (s_axil_araddr)
			A_CFG_UPPER, A_CFG_LOWER, A_RELOAD_UPPER, A_RELOAD_LOWER: rd_byte = 8'h00;
			A_FLAG_CLEAR: rd_byte = {6'h00, st.trim_en, 1'b0};
			A_STATUS:     rd_byte = status_byte;
			default:      rd_mapped = 1'b0;
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.xo_prev = crystal_raw_level;
		next_st.wake = 1'b0;

		// write address and data are taken independently, then answered together
		if (s_axil_awvalid && !st.aw_held && !st.bvalid) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = s_axil_awaddr;
		end
		if (s_axil_wvalid && !st.w_held && !st.bvalid) begin
			next_st.w_held = 1'b1;
			next_st.w_data = s_axil_wdata[7:0];
			next_st.w_lane = s_axil_wstrb[0];
		end
		if (wr_fire) begin
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = wr_mapped ? RESP_OKAY : RESP_SLVERR;
			if (st.w_lane) begin
				case (st.aw_addr)
					A_CFG_UPPER:    next_st.cfg_upper = st.w_data;
					A_CFG_LOWER:    next_st.cfg_lower = st.w_data;
					A_RELOAD_UPPER: next_st.reload_pending = st.w_data;
					A_RELOAD_LOWER: next_st.reload = {st.reload_pending, st.w_data};
					A_FLAG_CLEAR:   next_st.trim_en = st.w_data[CLR_TRIM];
					default:        next_st.bresp = RESP_SLVERR;
				endcase
			end
		end
		if (st.bvalid && s_axil_bready)
			next_st.bvalid = 1'b0;

		if (rd_fire) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = {24'h00_0000, rd_byte};
			next_st.rresp = rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (st.rvalid && s_axil_rready) begin
			next_st.rvalid = 1'b0;
		end

		// countdown: reload write restarts it; at zero the next tick reloads
		if (wr_rel_lower) begin
			next_st.count = {st.reload_pending, st.w_data};
		end else if (timer_tick) begin
			if (st.count == '0)
				next_st.count = st.reload;
			else
				next_st.count = st.count - 16'h0001;
		end

		// set wins over a clear in the same cycle
		if (wr_clear) begin
			next_st.latched = 1'b0;
			next_st.cold_start = 1'b0;
		end
		if (timeout_event) begin
			next_st.latched = 1'b1;
			next_st.wake = st.cfg_lower[CFG_ARM];
		end

		// crystal settle: count edges after enable
		if (!st.cfg_lower[CFG_XO_EN]) begin
			next_st.settle_count = '0;
			next_st.xo_settled = 1'b0;
		end else if (xo_tick && !st.xo_settled) begin
			next_st.settle_count = st.settle_count + 16'h0001;
			next_st.xo_settled = (st.settle_count + 16'h0001 >= SETTLE_EDGES);
		end

		// rc trim: runs for a fixed number of rc ticks; no rc oscillator means error
		if (!st.trim_en) begin
			next_st.trim_count = '0;
			next_st.trim_done = 1'b0;
			next_st.trim_error = 1'b0;
		end else if (!st.trim_done) begin
			if (!st.cfg_lower[CFG_RC_EN]) begin
				next_st.trim_done = 1'b1;
				next_st.trim_error = 1'b1;
			end else if (rc_tick) begin
				next_st.trim_count = st.trim_count + 16'h0001;
				next_st.trim_done = (st.trim_count + 16'h0001 >= TRIM_TICKS);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
			st.cfg_upper <= REG_RESET;
			st.cfg_lower <= REG_RESET;
			st.cold_start <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// backup ram loses power in sleep unless kept on
	assign backup_ram_sleep_power = !sleep_state || st.cfg_lower[CFG_BACKUP_RAM];
	assign wake_request   = st.wake;
	assign s_axil_awready = !st.aw_held && !st.bvalid;
	assign s_axil_wready  = !st.w_held && !st.bvalid;
	assign s_axil_bvalid  = st.bvalid;
	assign s_axil_bresp   = st.bresp;
	assign s_axil_arready = !st.rvalid;
	assign s_axil_rvalid  = st.rvalid;
	assign s_axil_rdata   = st.rdata;
	assign s_axil_rresp   = st.rresp;

	sequence s_upper_written;
		wr_rel_upper;
	endsequence

	sequence s_lower_written;
		wr_rel_lower;
	endsequence

	a_upper_deferred: assert property (@(posedge aclk) disable iff (!aresetn)
		s_upper_written |=> $stable(st.reload))
		else $error("upper reload byte applied before lower write");

	a_pair_applied: assert property (@(posedge aclk) disable iff (!aresetn)
		s_lower_written |=> st.reload == {$past(st.reload_pending), $past(st.w_data)}
		&& st.count == st.reload)
		else $error("reload pair not applied together");

	a_count_step: assert property (@(posedge aclk) disable iff (!aresetn)
		timer_tick && !wr_rel_lower && st.count != '0 |=> st.count == $past(st.count) - 16'h0001)
		else $error("countdown did not step on tick");

	a_zero_live: assert property (@(posedge aclk) disable iff (!aresetn)
		timeout_event && !wr_rel_lower |=> stat.live && status_byte[0])
		else $error("live zero bit missing after timeout");

	a_latch_holds: assert property (@(posedge aclk) disable iff (!aresetn)
		timeout_event ##1 (!wr_clear)[*3] |=> st.latched)
		else $error("timeout latch dropped without clear");

	a_clear_flags: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_clear && !timeout_event |=> !st.latched && !st.cold_start)
		else $error("flag clear did not clear both flags");

	a_cold_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		st.cold_start && !wr_clear |=> st.cold_start)
		else $error("cold start flag lost without clear");

	a_arm_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		timeout_event |=> wake_request == $past(st.cfg_lower[CFG_ARM]))
		else $error("wake request does not follow arm");

	a_trim_valid: assert property (@(posedge aclk) disable iff (!aresetn)
		!st.trim_en |-> !status_byte[5] && !status_byte[6])
		else $error("trim status shown while trim disabled");

	a_xo_settle: assert property (@(posedge aclk) disable iff (!aresetn)
		!st.cfg_lower[CFG_XO_EN] |=> !st.xo_settled)
		else $error("crystal settled while crystal disabled");

	a_ram_power: assert property (@(posedge aclk) disable iff (!aresetn)
		sleep_state && !st.cfg_lower[CFG_BACKUP_RAM] |-> !backup_ram_sleep_power)
		else $error("backup ram powered in sleep while not kept");

	a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire |=> s_axil_bvalid && !s_axil_awready && !s_axil_wready)
		else $error("write not answered one cycle after both parts held");

	sequence s_zero_tick;
		timer_tick && !wr_rel_lower && st.count == '0;
	endsequence

	sequence s_cfg_written;
		wr_cfg_lower;
	endsequence

	sequence s_status_read;
		rd_fire && s_axil_araddr == A_STATUS;
	endsequence

	sequence s_trim_no_rc;
		st.trim_en && !st.trim_done && !st.cfg_lower[CFG_RC_EN] && !wr_fire;
	endsequence

	a_tick_zero_reload: assert property (@(posedge aclk) disable iff (!aresetn)
		s_zero_tick |=> st.count == $past(st.reload))
		else $error("zero count not reloaded on tick");

	a_no_tick_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		!timer_tick && !wr_rel_lower |=> $stable(st.count))
		else $error("count moved without a tick");

	a_live_leaves: assert property (@(posedge aclk) disable iff (!aresetn)
		status_byte[0] && timer_tick && !wr_rel_lower && st.reload != '0 |=> !status_byte[0])
		else $error("live zero bit kept after reload");

	a_latch_set: assert property (@(posedge aclk) disable iff (!aresetn)
		timeout_event |=> status_byte[1])
		else $error("timeout not latched");

	a_wake_cause: assert property (@(posedge aclk) disable iff (!aresetn)
		wake_request |-> $past(timeout_event) && $past(st.cfg_lower[CFG_ARM]))
		else $error("wake request without armed timeout");

	a_trim_error: assert property (@(posedge aclk) disable iff (!aresetn)
		s_trim_no_rc |=> status_byte[6] && status_byte[5])
		else $error("trim without rc oscillator not flagged");

	a_cfg_apply: assert property (@(posedge aclk) disable iff (!aresetn)
		s_cfg_written |=> rc_osc_enable == $past(st.w_data[CFG_RC_EN])
		&& crystal_osc_enable == $past(st.w_data[CFG_XO_EN]))
		else $error("oscillator enables not taken from lower config");

	a_read_status: assert property (@(posedge aclk) disable iff (!aresetn)
		s_status_read |=> s_axil_rdata == {24'h00_0000, $past(status_byte)})
		else $error("status read data wrong");

	a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp))
		else $error("write response dropped before accepted");

	a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata))
		else $error("read data dropped before accepted");
endmodule

// *** shared/wakeup_pkg.sv ***
// Functional notes
// - countdown advances once per prescaler tick; code 0..7 divides 32.768 kHz by 1..65,536
// - upper reload byte is held until the lower byte is written, then both apply
// - when enabled, timer counts down from reload and raises a wake event at zero
// - status bit 0 shows live, unlatched, counter-at-zero condition
// - status bit 1 latches a timeout event until explicitly cleared
// - status bit 2 records a cold start and holds until cleared
// - writing 1 to flag-clear bit 0 clears timeout latch and cold-start flag
// - flag-clear bit 1 enables rc trim; status bit 5 shows trim finished
// - status bit 6 shows rc trim ended with error, valid only while trim enabled
// - status bit 4 shows crystal settled, meaningful only while crystal enabled
// - status bit 3 shows instantaneous crystal output level
// - lower config bit 4 picks timer source: 1 rc oscillator, 0 crystal
// - lower config bit 3 keeps backup ram powered during sleep when 1
// - lower config bit 0 arms wake-up on timeout; 0 blocks the wake-up
package wakeup_pkg;
	localparam int unsigned CLK_HZ  = 20_000_000;
	localparam int unsigned SLOW_HZ = 32_768;
	localparam int          PHASE_W = 25;
	localparam int          PRESC_W = 3;
	localparam int          COUNT_W = 16;

	// printed offsets are not all word aligned: they are indices, byte address is 4x
	localparam logic [9:0]  IDX_CFG_UPPER    = 10'h30c;
	localparam logic [9:0]  IDX_CFG_LOWER    = 10'h30d;
	localparam logic [9:0]  IDX_RELOAD_UPPER = 10'h30e;
	localparam logic [9:0]  IDX_RELOAD_LOWER = 10'h30f;
	localparam logic [9:0]  IDX_FLAG_CLEAR   = 10'h310;
	localparam logic [9:0]  IDX_STATUS       = 10'h311;
	localparam int          ADDR_W           = 12;

	localparam logic [7:0]  REG_RESET        = 8'h00;

	localparam int CFG_RC_EN   = 6;
	localparam int CFG_XO_EN   = 5;
	localparam int CFG_SRC_SEL = 4;
	localparam int CFG_BACKUP_RAM   = 3;
	localparam int CFG_ARM     = 0;
	localparam int CLR_FLAGS   = 0;
	localparam int CLR_TRIM    = 1;

	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	localparam logic [COUNT_W-1:0] SETTLE_EDGES_DEF = 16'h0400;
	localparam logic [COUNT_W-1:0] TRIM_TICKS_DEF   = 16'h0040;

	// divider minus one, per prescaler code
	function automatic logic [COUNT_W-1:0] div_last(input logic [PRESC_W-1:0] sel);
		case (sel)
			3'h0:    div_last = 16'h0000;
			3'h1:    div_last = 16'h0003;
			3'h2:    div_last = 16'h0007;
			3'h3:    div_last = 16'h000f;
			3'h4:    div_last = 16'h007f;
			3'h5:    div_last = 16'h03ff;
			3'h6:    div_last = 16'h1fff;
			default: div_last = 16'hffff;
		endcase
	endfunction

	typedef struct packed {
		logic live;
		logic latched;
		logic cold_start;
		logic xo_level;
		logic xo_settled;
		logic trim_done;
		logic trim_error;
	} wake_status_t;

	typedef struct packed {
		logic [7:0]         cfg_upper;
		logic [7:0]         cfg_lower;
		logic [7:0]         reload_pending;
		logic [COUNT_W-1:0] reload;
		logic [COUNT_W-1:0] count;
		logic               trim_en;
		logic               latched;
		logic               cold_start;
		logic               trim_done;
		logic               trim_error;
		logic [COUNT_W-1:0] trim_count;
		logic               xo_settled;
		logic [COUNT_W-1:0] settle_count;
		logic               xo_prev;
		logic               wake;
		logic               aw_held;
		logic [ADDR_W-1:0]  aw_addr;
		logic               w_held;
		logic [7:0]         w_data;
		logic               w_lane;
		logic               bvalid;
		logic [1:0]         bresp;
		logic               rvalid;
		logic [31:0]        rdata;
		logic [1:0]         rresp;
	} wake_state_t;
endpackage

// *** tb/test_wakeup_controller.sv ***
module test_wakeup_controller import wakeup_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [ADDR_W-1:0] A_CU = {IDX_CFG_UPPER, 2'b00};
	localparam logic [ADDR_W-1:0] A_CL = {IDX_CFG_LOWER, 2'b00};
	localparam logic [ADDR_W-1:0] A_RU = {IDX_RELOAD_UPPER, 2'b00};
	localparam logic [ADDR_W-1:0] A_RL = {IDX_RELOAD_LOWER, 2'b00};
	localparam logic [ADDR_W-1:0] A_FC = {IDX_FLAG_CLEAR, 2'b00};
	localparam logic [ADDR_W-1:0] A_ST = {IDX_STATUS, 2'b00};
	localparam int                LIMIT = 80000;

	typedef struct packed {
		logic              is_wr;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        data;
		logic [1:0]        resp;
		logic [31:0]       rdata;
	} row_t;

	// status reads 0x05 straight after reset; write-only places read as zero
	row_t rows [8] = '{
		'{1'b0, A_ST, 8'h00, RESP_OKAY, 32'h0000_0005},
		'{1'b0, A_CU, 8'h00, RESP_OKAY, 32'h0000_0000},
		'{1'b0, A_CL, 8'h00, RESP_OKAY, 32'h0000_0000},
		'{1'b0, A_RU, 8'h00, RESP_OKAY, 32'h0000_0000},
		'{1'b0, A_RL, 8'h00, RESP_OKAY, 32'h0000_0000},
		'{1'b1, A_ST, 8'h00, RESP_SLVERR, 32'h0000_0000},
		'{1'b0, 12'hc48, 8'h00, RESP_SLVERR, 32'h0000_0000},
		'{1'b1, 12'hc2c, 8'h00, RESP_SLVERR, 32'h0000_0000}
	};

	logic              aclk;
	logic              aresetn;
	logic [ADDR_W-1:0] s_axil_awaddr;
	logic              s_axil_awvalid;
	logic              s_axil_awready;
	logic [31:0]       s_axil_wdata;
	logic              s_axil_wvalid;
	logic              s_axil_wready;
	logic [1:0]        s_axil_bresp;
	logic              s_axil_bvalid;
	logic              s_axil_bready;
	logic [ADDR_W-1:0] s_axil_araddr;
	logic              s_axil_arvalid;
	logic              s_axil_arready;
	logic [31:0]       s_axil_rdata;
	logic [1:0]        s_axil_rresp;
	logic              s_axil_rvalid;
	logic              s_axil_rready;
	logic              crystal_raw_level;
	logic              sleep_state;
	logic              rc_osc_enable;
	logic              crystal_osc_enable;
	logic              backup_ram_sleep_power;
	logic              wake_request;
	logic              xo_run;
	logic [4:0]        xo_cnt;
	int                cyc;
	int                n_fail;
	int                compares;

	wakeup_controller #(
		.SETTLE_EDGES(16'h0004),
		.TRIM_TICKS  (16'h0002)
	) wakeup_controller_inst (
		.aclk                  (aclk),
		.aresetn               (aresetn),
		.s_axil_awaddr         (s_axil_awaddr),
		.s_axil_awprot         (3'h0),
		.s_axil_awvalid        (s_axil_awvalid),
		.s_axil_awready        (s_axil_awready),
		.s_axil_wdata          (s_axil_wdata),
		.s_axil_wstrb          (4'h1),
		.s_axil_wvalid         (s_axil_wvalid),
		.s_axil_wready         (s_axil_wready),
		.s_axil_bresp          (s_axil_bresp),
		.s_axil_bvalid         (s_axil_bvalid),
		.s_axil_bready         (s_axil_bready),
		.s_axil_araddr         (s_axil_araddr),
		.s_axil_arprot         (3'h0),
		.s_axil_arvalid        (s_axil_arvalid),
		.s_axil_arready        (s_axil_arready),
		.s_axil_rdata          (s_axil_rdata),
		.s_axil_rresp          (s_axil_rresp),
		.s_axil_rvalid         (s_axil_rvalid),
		.s_axil_rready         (s_axil_rready),
		.crystal_raw_level     (crystal_raw_level),
		.sleep_state           (sleep_state),
		.rc_osc_enable         (rc_osc_enable),
		.crystal_osc_enable    (crystal_osc_enable),
		.backup_ram_sleep_power(backup_ram_sleep_power),
		.wake_request          (wake_request)
	);

	always #25 aclk = ~aclk;

	// crystal stand-in: rising edge every 20 cycles while running
	always @(posedge aclk) begin
		if (xo_run) begin
			xo_cnt <= (xo_cnt == 5'h09) ? 5'h00 : xo_cnt + 5'h01;
			if (xo_cnt == 5'h09) crystal_raw_level <= ~crystal_raw_level;
		end
	end

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			n_fail++;
			test_done();
		end
	end

	task automatic test_done();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t %s: got %h want %h", $time, what, seen, exp);
		end
	endtask

	// handshakes are judged at the falling edge so no race with the design's own update
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v, output logic [1:0] r);
		logic ta, tw, da, dw, got;
		@(posedge aclk);
		s_axil_awaddr  <= a;
		s_axil_wdata   <= {24'h00_0000, v};
		s_axil_awvalid <= 1'b1;
		s_axil_wvalid  <= 1'b1;
		da = 1'b0;
		dw = 1'b0;
		got = 1'b0;
		while (!(da && dw)) begin
			@(negedge aclk);
			ta = s_axil_awvalid && s_axil_awready;
			tw = s_axil_wvalid && s_axil_wready;
			@(posedge aclk);
			if (ta) s_axil_awvalid <= 1'b0;
			if (tw) s_axil_wvalid <= 1'b0;
			da = da || ta;
			dw = dw || tw;
		end
		s_axil_bready <= 1'b1;
		while (!got) begin
			@(negedge aclk);
			got = s_axil_bvalid;
			r = s_axil_bresp;
			@(posedge aclk);
		end
		s_axil_bready <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, got;
		@(posedge aclk);
		s_axil_araddr  <= a;
		s_axil_arvalid <= 1'b1;
		s_axil_rready  <= 1'b1;
		ta = 1'b0;
		got = 1'b0;
		while (!ta) begin
			@(negedge aclk);
			ta = s_axil_arready;
			@(posedge aclk);
		end
		s_axil_arvalid <= 1'b0;
		while (!got) begin
			@(negedge aclk);
			got = s_axil_rvalid;
			d = s_axil_rdata;
			r = s_axil_rresp;
			@(posedge aclk);
		end
		s_axil_rready <= 1'b0;
	endtask

	task automatic wait_wake(input int lim, output int at);
		at = -1;
		for (int k = 0; k < lim && at < 0; k++) begin
			@(negedge aclk);
			if (wake_request === 1'b1) at = cyc;
		end
		@(negedge aclk);
		chk({31'h0, wake_request}, 32'h0000_0000, "wake pulse width");
	endtask

	// rc ticks come from a fractional divider, so spacing is allowed a small jitter
	task automatic meas(input int lim, input int lo, input int hi);
		int t1, t2;
		wait_wake(lim, t1);
		wait_wake(lim, t2);
		chk({31'h0, (t1 >= 0 && t2 - t1 >= lo && t2 - t1 <= hi)}, 32'h0000_0001, "spacing");
	endtask

	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		int          n;
		aclk = 1'b0;
		aresetn = 1'b0;
		s_axil_awaddr = '0;
		s_axil_awvalid = 1'b0;
		s_axil_wdata = '0;
		s_axil_wvalid = 1'b0;
		s_axil_bready = 1'b0;
		s_axil_araddr = '0;
		s_axil_arvalid = 1'b0;
		s_axil_rready = 1'b0;
		crystal_raw_level = 1'b0;
		sleep_state = 1'b1;
		xo_run = 1'b0;
		xo_cnt = 5'h00;
		cyc = 0;
		n_fail = 0;
		compares = 0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk({31'h0, backup_ram_sleep_power}, 32'h0000_0000, "ram power at reset");
		foreach (rows[i]) begin
			if (rows[i].is_wr) begin
				wr(rows[i].addr, rows[i].data, r);
			end else begin
				rd(rows[i].addr, d, r);
				chk(d, rows[i].rdata, "read data");
			end
			chk({30'h0, r}, {30'h0, rows[i].resp}, "response");
		end
		wr(A_FC, 8'h01, r);
		rd(A_ST, d, r);
		chk(d, 32'h0000_0001, "flags cleared");
		wr(A_CU, 8'h00, r);
		wr(A_CL, 8'h59, r);
		chk({30'h0, rc_osc_enable, crystal_osc_enable}, 32'h0000_0002, "osc enables");
		chk({31'h0, backup_ram_sleep_power}, 32'h0000_0001, "ram kept");
		wr(A_RU, 8'h00, r);
		wr(A_RL, 8'h03, r);
		rd(A_ST, d, r);
		chk(d, 32'h0000_0000, "count running");
		meas(3000, 2439, 2444);
		rd(A_ST, d, r);
		chk(d, 32'h0000_0003, "live and latched");
		wr(A_RU, 8'h02, r);
		meas(3000, 2439, 2444);
		wr(A_RU, 8'h00, r);
		wr(A_RL, 8'h01, r);
		meas(3000, 1219, 1223);
		wr(A_CU, 8'h01, r);
		wr(A_CL, 8'h59, r);
		meas(12000, 4880, 4886);
		wr(A_CU, 8'h00, r);
		wr(A_CL, 8'h58, r);
		wr(A_FC, 8'h01, r);
		n = 0;
		repeat (3000) begin
			@(negedge aclk);
			if (wake_request === 1'b1) n++;
		end
		chk(32'(n), 32'h0000_0000, "disarmed wake");
		rd(A_ST, d, r);
		chk(d & 32'h0000_0006, 32'h0000_0002, "latched without wake");
		wr(A_FC, 8'h02, r);
		rd(A_FC, d, r);
		chk(d & 32'h0000_0002, 32'h0000_0002, "trim enable readback");
		rd(A_ST, d, r);
		chk(d & 32'h0000_0060, 32'h0000_0000, "trim running");
		repeat (1500) @(posedge aclk);
		rd(A_ST, d, r);
		chk(d & 32'h0000_0060, 32'h0000_0020, "trim done clean");
		wr(A_FC, 8'h00, r);
		rd(A_ST, d, r);
		chk(d & 32'h0000_0060, 32'h0000_0000, "trim off");
		wr(A_CU, 8'h00, r);
		wr(A_CL, 8'h29, r);
		chk({30'h0, rc_osc_enable, crystal_osc_enable}, 32'h0000_0001, "crystal on");
		rd(A_ST, d, r);
		chk(d & 32'h0000_0018, 32'h0000_0000, "not settled");
		xo_run <= 1'b1;
		meas(400, 40, 40);
		// a few more crystal edges so the settle count is surely reached
		repeat (60) @(posedge aclk);
		xo_run <= 1'b0;
		for (int lv = 0; lv < 2; lv++) begin
			@(posedge aclk);
			crystal_raw_level <= lv[0];
			rd(A_ST, d, r);
			chk(d & 32'h0000_0018, {27'h0, 1'b1, lv[0], 3'h0}, "crystal bits");
		end
		wr(A_FC, 8'h02, r);
		rd(A_ST, d, r);
		chk(d & 32'h0000_0060, 32'h0000_0060, "trim error");
		wr(A_FC, 8'h00, r);
		wr(A_CU, 8'h00, r);
		wr(A_CL, 8'h21, r);
		chk({31'h0, backup_ram_sleep_power}, 32'h0000_0000, "ram dropped");
		@(posedge aclk);
		sleep_state <= 1'b0;
		@(negedge aclk);
		chk({31'h0, backup_ram_sleep_power}, 32'h0000_0001, "ram awake");
		@(posedge aclk);
		aresetn <= 1'b0;
		crystal_raw_level <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(A_ST, d, r);
		chk(d, 32'h0000_0005, "cold start again");
		test_done();
	end
endmodule
